// ==== src/qr_cfg.svh ====
// Offsets, field positions, reset values and timing figures of the turn-on control.
// Assumes a 100 MHz core clock; included by the register slave, the control and the bench.
`ifndef QR_CFG_SVH
`define QR_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define QR_CTRL_OFS      12'h000
`define QR_STATUS_OFS    12'h004
`define QR_CYCLES_OFS    12'h008
`define QR_SKIPS_OFS     12'h00c

// ==========================================================
// Field positions and reset values
`define QR_CTRL_EN_BIT   0
`define QR_CTRL_HF_BIT   1
`define QR_CTRL_RST      32'h0000_0001
`define QR_ST_GATE_BIT   0
`define QR_ST_QR_BIT     1
`define QR_ST_LONG_BIT   2
`define QR_ST_STATE_LSB  4

// ==========================================================
// Timing figures, each in its own unit
`define QR_CLK_KHZ       100000
`define QR_CLK_NS        10
`define QR_FLIM_L_KHZ    136
`define QR_FLIM_H_KHZ    225
`define QR_TBLANK_S_NS   2500
`define QR_TBLANK_L_NS   6300
`define QR_TSTROBE_NS    1000
`define QR_TON_DLY_NS    200
`define QR_FSTART_KHZ    20
`define QR_FMIN_KHZ      12

`endif

// ==== src/qr_pkg.sv ====
// Types shared by the turn-on control and its register slave.
// Assumes qr_cfg.svh for the numeric figures.
package qr_pkg;

  // ==========================================================
  // Gate sequencer states
  typedef enum logic [3:0]
  {
    ST_OFF_BLANK = 4'b0001,
    ST_OFF_WAIT  = 4'b0010,
    ST_ON_DELAY  = 4'b0100,
    ST_ON        = 4'b1000
  } gate_state_t;

  typedef enum logic [1:0]
  {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage

// ==== src/edge_sync.sv ====
// Two-stage synchroniser with a two-cycle glitch filter and edge pulses.
// Assumes an asynchronous comparator level on async_in.
`timescale 1ns/1ps
module edge_sync
  import qr_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1;
  logic s2;
  logic s3;
  logic level_d;
  logic next_level;

  // ==========================================================
  // Filter: a level must hold two samples before it counts
  always_comb
  begin
    next_level = level;
    if (s2 == s3)
    begin
      next_level = s3; // RQ16
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level   <= 1'b0;
      level_d <= 1'b0;
    end
    else if (ce)
    begin
      s1      <= async_in;
      s2      <= s1;
      s3      <= s2;
      level   <= next_level;
      level_d <= level;
    end
  end

  assign rise = level & ~level_d;
  assign fall = ~level & level_d;

endmodule

// ==== src/axil_regs.sv ====
// AXI4-Lite slave holding the control word and reading back block state.
// Assumes one outstanding write and one outstanding read from the master.
`include "qr_cfg.svh"
`timescale 1ns/1ps
module axil_regs
  import qr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] status,
  input  wire logic [31:0] cycles,
  input  wire logic [31:0] skips,
  output logic [31:0]      ctrl
);

  logic        aw_full;
  logic        w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_full;
  logic        next_w_full;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [31:0] next_ctrl;

  // ==========================================================
  // Write and read channels
  always_comb
  begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_ctrl    = ctrl;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // Commit only once both halves are held and the last answer is gone
    if (aw_full && w_full && !s_axi_bvalid)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr == `QR_CTRL_OFS)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (w_strb[b])
          begin
            next_ctrl[8*b +: 8] = w_data[8*b +: 8];
          end
        end
      end
      else if (aw_addr == `QR_STATUS_OFS || aw_addr == `QR_CYCLES_OFS || aw_addr == `QR_SKIPS_OFS)
      begin
        next_bresp = RESP_OKAY;
      end
      else
      begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (s_axi_araddr == `QR_CTRL_OFS)
      begin
        next_rdata = ctrl;
      end
      else if (s_axi_araddr == `QR_STATUS_OFS)
      begin
        next_rdata = status;
      end
      else if (s_axi_araddr == `QR_CYCLES_OFS)
      begin
        next_rdata = cycles;
      end
      else if (s_axi_araddr == `QR_SKIPS_OFS)
      begin
        next_rdata = skips;
      end
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      ctrl          <= `QR_CTRL_RST;
    end
    else if (ce)
    begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      ctrl          <= next_ctrl;
    end
  end

endmodule

// ==== src/qr_valley_skip_turnon_control.sv ====
// Turn-on gating of a quasi-resonant flyback switch, with AXI4-Lite control.
// Assumes asynchronous comparators for arming, trigger, 1V level and current limit.
//
// Functional notes
// (RQ1) Oscillator caps rate at 136 or 225 kHz
// (RQ2) Oscillator period restarts at every turn-on
// (RQ3) Late falling trigger turns on, resynchronizes
// (RQ4) Early falling trigger is ignored
// (RQ5) Ringing re-arms; valleys skipped until period ends
// (RQ6) Blanking after turn-off inhibits, may extend period
// (RQ7) Blanking lengths 2.5 us and 6.3 us
// (RQ8) Level above 1V picks short blanking
// (RQ9) Never armed: switch at fixed starter frequency
// (RQ10) Armed operation times turn-on from trigger
// (RQ11) Arm stuck high: fall back to minimum frequency
// (RQ12) Current limit turns switch off each cycle
// (RQ13) Trigger needs prior arming; short delay follows
// (RQ14) Level sampled at strobe delay after turn-off
// (RQ15) All intervals counted in clocks, parameterized
// (RQ16) Comparators synchronized and deglitched before edges
`include "qr_cfg.svh"
`timescale 1ns/1ps
module qr_valley_skip_turnon_control
  import qr_pkg::*;
#(
  parameter int unsigned OSC_L_CYC   = (`QR_CLK_KHZ + `QR_FLIM_L_KHZ - 1) / `QR_FLIM_L_KHZ,
  parameter int unsigned OSC_H_CYC   = (`QR_CLK_KHZ + `QR_FLIM_H_KHZ - 1) / `QR_FLIM_H_KHZ,
  parameter int unsigned BLANK_S_CYC = (`QR_TBLANK_S_NS + `QR_CLK_NS - 1) / `QR_CLK_NS,
  parameter int unsigned BLANK_L_CYC = (`QR_TBLANK_L_NS + `QR_CLK_NS - 1) / `QR_CLK_NS,
  parameter int unsigned STROBE_CYC  = (`QR_TSTROBE_NS + `QR_CLK_NS - 1) / `QR_CLK_NS,
  parameter int unsigned TON_DLY_CYC = (`QR_TON_DLY_NS + `QR_CLK_NS - 1) / `QR_CLK_NS,
  parameter int unsigned STARTER_CYC = (`QR_CLK_KHZ + `QR_FSTART_KHZ - 1) / `QR_FSTART_KHZ,
  parameter int unsigned MINF_CYC    = (`QR_CLK_KHZ + `QR_FMIN_KHZ - 1) / `QR_FMIN_KHZ
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        arm_cmp,
  input  wire logic        trig_cmp,
  input  wire logic        level_cmp,
  input  wire logic        ilim_cmp,
  output logic             gate_on,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam logic [15:0] OSC_L   = 16'(OSC_L_CYC);
  localparam logic [15:0] OSC_H   = 16'(OSC_H_CYC);
  localparam logic [15:0] BLANK_S = 16'(BLANK_S_CYC);
  localparam logic [15:0] BLANK_L = 16'(BLANK_L_CYC);
  localparam logic [15:0] STROBE  = 16'(STROBE_CYC);
  localparam logic [15:0] TON_DLY = 16'(TON_DLY_CYC);
  localparam logic [15:0] STARTER = 16'(STARTER_CYC);
  localparam logic [15:0] MINF    = 16'(MINF_CYC);

  gate_state_t state;
  gate_state_t next_state;
  logic [15:0] on_cnt;
  logic [15:0] off_cnt;
  logic [15:0] dly_cnt;
  logic        armed;
  logic        arm_hi_seen;
  logic        arm_lo_seen;
  logic        blank_long;
  logic        qr_mode;
  logic [31:0] cycles;
  logic [31:0] skips;
  logic [15:0] next_on_cnt;
  logic [15:0] next_off_cnt;
  logic [15:0] next_dly_cnt;
  logic        next_armed;
  logic        next_arm_hi_seen;
  logic        next_arm_lo_seen;
  logic        next_blank_long;
  logic        next_qr_mode;
  logic [31:0] next_cycles;
  logic [31:0] next_skips;
  logic        next_gate_on;
  logic        arm_lvl;
  logic        arm_rise;
  logic        trig_fall;
  logic        level_hi;
  logic        ilim_lvl;
  logic [31:0] ctrl;
  logic [31:0] status;
  logic        enable;
  logic [15:0] period;
  logic [15:0] blank_len;
  logic        osc_done;
  logic        blank_done;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // ==========================================================
  // Comparator inputs
  edge_sync u_arm (.clock(clock), .rst_n(rst_n), .ce(ce), .async_in(arm_cmp),
                   .level(arm_lvl), .rise(arm_rise), .fall()); // RQ16
  edge_sync u_trig (.clock(clock), .rst_n(rst_n), .ce(ce), .async_in(trig_cmp),
                    .level(), .rise(), .fall(trig_fall)); // RQ16
  edge_sync u_lvl (.clock(clock), .rst_n(rst_n), .ce(ce), .async_in(level_cmp),
                   .level(level_hi), .rise(), .fall());
  edge_sync u_ilim (.clock(clock), .rst_n(rst_n), .ce(ce), .async_in(ilim_cmp),
                    .level(ilim_lvl), .rise(), .fall()); // RQ16

  // ==========================================================
  // Register slave
  assign status = {24'h000000, state, 1'b0, blank_long, qr_mode, gate_on};

  axil_regs u_regs (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .status(status), .cycles(cycles), .skips(skips), .ctrl(ctrl)
  );

  assign enable     = ctrl[`QR_CTRL_EN_BIT];
  assign period     = ctrl[`QR_CTRL_HF_BIT] ? OSC_H : OSC_L; // RQ1 RQ15
  assign blank_len  = blank_long ? BLANK_L : BLANK_S; // RQ7
  assign osc_done   = on_cnt >= period; // RQ2
  assign blank_done = off_cnt >= blank_len;

  // ==========================================================
  // Gate sequencer
  always_comb
  begin
    next_state       = state;
    next_on_cnt      = sat_inc(on_cnt); // RQ15
    next_off_cnt     = sat_inc(off_cnt);
    next_dly_cnt     = dly_cnt;
    next_armed       = armed;
    next_arm_hi_seen = arm_hi_seen;
    next_arm_lo_seen = arm_lo_seen;
    next_blank_long  = blank_long;
    next_qr_mode     = qr_mode;
    next_cycles      = cycles;
    next_skips       = skips;
    next_gate_on     = gate_on;
    case (state)
      ST_ON:
      begin
        // Sync latency stands in for the comparator path delay
        if (ilim_lvl || !enable)
        begin
          next_state       = ST_OFF_BLANK; // RQ12
          next_gate_on     = 1'b0;
          next_off_cnt     = 16'h0000;
          next_armed       = 1'b0;
          next_arm_hi_seen = 1'b0;
          next_arm_lo_seen = 1'b0;
        end
      end
      ST_OFF_BLANK:
      begin
        if (off_cnt == STROBE)
        begin
          next_blank_long = !level_hi; // RQ8 RQ14
        end
        // Ringing right after turn-off must not arm anything
        if (off_cnt > STROBE && blank_done)
        begin
          next_state = ST_OFF_WAIT; // RQ6
        end
      end
      ST_OFF_WAIT:
      begin
        next_arm_hi_seen = arm_hi_seen | arm_lvl;
        next_arm_lo_seen = arm_lo_seen | ~arm_lvl;
        if (arm_rise)
        begin
          next_armed = 1'b1; // RQ5
        end
        if (trig_fall && armed)
        begin
          if (osc_done && enable)
          begin
            next_state   = ST_ON_DELAY; // RQ3 RQ10 RQ13
            next_dly_cnt = 16'h0000;
            next_qr_mode = 1'b1;
          end
          else
          begin
            // A fresh arming edge in the same cycle wins over the disarm
            next_armed = arm_rise; // RQ4 RQ5
            next_skips = skips + 32'h0000_0001;
          end
        end
        else if (osc_done && enable && !arm_hi_seen && !arm_lvl && on_cnt >= STARTER)
        begin
          next_state   = ST_ON; // RQ9
          next_gate_on = 1'b1;
          next_on_cnt  = 16'h0000;
          next_qr_mode = 1'b0;
          next_cycles  = cycles + 32'h0000_0001;
        end
        else if (osc_done && enable && !arm_lo_seen && arm_lvl && on_cnt >= MINF)
        begin
          next_state   = ST_ON; // RQ11
          next_gate_on = 1'b1;
          next_on_cnt  = 16'h0000;
          next_qr_mode = 1'b0;
          next_cycles  = cycles + 32'h0000_0001;
        end
      end
      ST_ON_DELAY:
      begin
        next_dly_cnt = sat_inc(dly_cnt);
        if (dly_cnt >= TON_DLY - 16'h0001)
        begin
          next_state   = ST_ON; // RQ13
          next_gate_on = 1'b1;
          next_on_cnt  = 16'h0000; // RQ2 RQ3
          next_cycles  = cycles + 32'h0000_0001;
        end
      end
      default:
      begin
        next_state   = ST_OFF_BLANK;
        next_gate_on = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= ST_OFF_BLANK;
      on_cnt      <= 16'h0000;
      off_cnt     <= 16'h0000;
      dly_cnt     <= 16'h0000;
      armed       <= 1'b0;
      arm_hi_seen <= 1'b0;
      arm_lo_seen <= 1'b0;
      blank_long  <= 1'b1;
      qr_mode     <= 1'b0;
      cycles      <= 32'h0000_0000;
      skips       <= 32'h0000_0000;
      gate_on     <= 1'b0;
    end
    else if (ce)
    begin
      state       <= next_state;
      on_cnt      <= next_on_cnt;
      off_cnt     <= next_off_cnt;
      dly_cnt     <= next_dly_cnt;
      armed       <= next_armed;
      arm_hi_seen <= next_arm_hi_seen;
      arm_lo_seen <= next_arm_lo_seen;
      blank_long  <= next_blank_long;
      qr_mode     <= next_qr_mode;
      cycles      <= next_cycles;
      skips       <= next_skips;
      gate_on     <= next_gate_on;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_strobe_hi;
    ce && state == ST_OFF_BLANK && off_cnt == STROBE && level_hi;
  endsequence

  sequence s_turn_on;
    ce && state != ST_ON && next_state == ST_ON;
  endsequence

  AST_MAX_FREQ: assert property (s_turn_on |-> on_cnt >= period) // RQ1
    else $error("Turn-on before oscillator period");
  AST_RESYNC: assert property (s_turn_on |=> gate_on && on_cnt == 16'h0000) // RQ2
    else $error("Oscillator not restarted at turn-on");
  AST_VALLEY_ON: assert property (ce && state == ST_OFF_WAIT && trig_fall && armed && osc_done && enable
                                  |=> state == ST_ON_DELAY) // RQ3
    else $error("Late trigger did not start turn-on");
  AST_EARLY_IGNORED: assert property (ce && state == ST_OFF_WAIT && trig_fall && armed && !osc_done
                                      |=> state == ST_OFF_WAIT && !gate_on) // RQ4
    else $error("Early trigger was honoured");
  AST_REARM: assert property (ce && state == ST_OFF_WAIT && arm_rise && !trig_fall |=> armed) // RQ5
    else $error("Arming edge lost");
  AST_BLANK_INHIBIT: assert property (ce && state == ST_OFF_BLANK && !blank_done |=> !gate_on) // RQ6
    else $error("Turn-on inside blanking");
  AST_BLANK_SELECT: assert property (s_strobe_hi ##1 (ce && state == ST_OFF_BLANK)[*2] |-> !blank_long) // RQ8
    else $error("Short blanking not chosen for high level");
  AST_STARTER: assert property (ce && state == ST_OFF_WAIT && !trig_fall && enable && osc_done && !arm_hi_seen
                                && !arm_lvl && on_cnt >= STARTER |=> gate_on && !qr_mode) // RQ9
    else $error("Starter turn-on missing");
  AST_MIN_FREQ: assert property (ce && state == ST_OFF_WAIT && arm_lvl && on_cnt < MINF && !armed
                                 |=> !gate_on) // RQ11
    else $error("Stuck arm switched above minimum rate");
  AST_ILIM_OFF: assert property (ce && state == ST_ON && ilim_lvl |=> !gate_on ##0 state == ST_OFF_BLANK) // RQ12
    else $error("Current limit did not turn off");
  AST_ARM_FIRST: assert property (ce && state == ST_OFF_WAIT && trig_fall && !armed
                                  |=> state == ST_OFF_WAIT) // RQ13
    else $error("Unarmed trigger honoured");
  AST_ON_DELAY: assert property (ce && state == ST_ON_DELAY && dly_cnt == TON_DLY - 16'h0001
                                 |=> gate_on) // RQ13
    else $error("Turn-on delay wrong");

endmodule

// ==== test/comparator_model.sv ====
// Analog side of the control: sense-input comparators and drain current limit.
// Assumes gate_on from the control; every level is driven in every cycle.
`timescale 1ns/1ps
module comparator_model
#(
  parameter int ON_CYC = 40
)
(
  input  wire logic       clock,
  input  wire logic       gate_on,
  input  wire logic [1:0] mode,
  input  wire logic       level_hi,
  output logic            arm_cmp,
  output logic            trig_cmp,
  output logic            level_cmp,
  output logic            ilim_cmp
);
  // ==========================================================
  // Time since the last gate change
  logic g = 1'b0;
  int   t = 0;

  always @(posedge clock)
  begin
    g <= gate_on;
    t <= (gate_on !== g) ? 0 : t + 1;
  end

  // ==========================================================
  // Mode 0 silent, 1 ringing of 100 cycles after turn-off, 2 stuck above arming
  assign ilim_cmp  = g && t >= ON_CYC;
  assign arm_cmp   = mode == 2'h2 || (mode == 2'h1 && !g && t % 100 < 50);
  assign trig_cmp  = arm_cmp;
  assign level_cmp = level_hi;
endmodule

// ==== test/qr_valley_skip_turnon_control_test.sv ====
// Self-checking bench: register slave, starter, valley skipping, blanking, fallback.
// Assumes the comparator model on the analog side and a 100 MHz clock.
`include "qr_cfg.svh"
`timescale 1ns/1ps
module qr_valley_skip_turnon_control_test
  import qr_pkg::*;
;
  logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1, level_hi = 1'b1, gate_on;
  logic        arm_cmp, trig_cmp, level_cmp, ilim_cmp;
  logic [1:0]  mode = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          n_errors = 0, checked = 0;

  always #5 clock = ~clock;

  // Short starter and fallback periods keep the run brief
  qr_valley_skip_turnon_control #(.STARTER_CYC(800), .MINF_CYC(1000)) i_dut
  (
    .clock, .rst_n, .ce, .arm_cmp, .trig_cmp, .level_cmp, .ilim_cmp, .gate_on,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  comparator_model #(.ON_CYC(40)) i_ana
  (
    .clock, .gate_on, .mode, .level_hi, .arm_cmp, .trig_cmp, .level_cmp, .ilim_cmp
  );

  // ==========================================================
  // Report
  task automatic results;
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // ==========================================================
  // Bus cycles; release each channel at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clock);
        return;
      end
    end
    chk(0, 1, 1);
    results();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
        return;
      end
    end
    chk(0, 1, 1);
    results();
  endtask

  // Cycles to the next turn-on, and cycles the gate stood high meanwhile
  task automatic rise(output int n, output int hi);
    logic p;
    p = gate_on;
    hi = 0;
    for (n = 1; n < 4000; n++)
    begin
      @(posedge clock);
      hi += (gate_on === 1'b1);
      if (gate_on === 1'b1 && p === 1'b0) return;
      p = gate_on;
    end
    chk(0, 1, 1);
    results();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`QR_CTRL_OFS, d, r);
    chk(d, `QR_CTRL_RST, `QR_CTRL_RST);
    wr(`QR_STATUS_OFS, 32'hffff_ffff, r);
    chk(r, RESP_OKAY, RESP_OKAY);
    rd(12'h010, d, r);
    chk(d, 32'h0, 32'h0);
    chk(r, RESP_SLVERR, RESP_SLVERR);
    wr(12'h010, 32'h0, r);
    chk(r, RESP_SLVERR, RESP_SLVERR);
  endtask

  task automatic t_starter;
    int n, h;
    rise(n, h);
    rise(n, h);
    chk(n, 800, 840);
    chk(h, 41, 52);
  endtask

  // Ringing of 100 cycles: valleys before the period end are skipped
  task automatic t_qr;
    int n, h;
    logic [31:0] s0, s1;
    logic [1:0]  r;
    mode <= 2'h1;
    rd(`QR_SKIPS_OFS, s0, r);
    repeat (3) rise(n, h);
    chk(n, 736, 870);
    rd(`QR_SKIPS_OFS, s1, r);
    chk(s1 - s0, 1, 100);
    rd(`QR_STATUS_OFS, s1, r);
    chk(s1[2:1], 2'b01, 2'b01);
    wr(`QR_CTRL_OFS, 32'h3, r);
    repeat (3) rise(n, h);
    chk(n, 445, 570);
    level_hi <= 1'b0;
    repeat (3) rise(n, h);
    chk(n, 670, 1000);
    rd(`QR_STATUS_OFS, s1, r);
    chk(s1[2], 1'b1, 1'b1);
    wr(`QR_CTRL_OFS, 32'h1, r);
  endtask

  task automatic t_stuck;
    int n, h;
    logic [31:0] c0, c1;
    logic [1:0]  r;
    mode <= 2'h2;
    rd(`QR_CYCLES_OFS, c0, r);
    repeat (3) rise(n, h);
    chk(n, 980, 1060);
    rd(`QR_CYCLES_OFS, c1, r);
    chk(c1 - c0, 3, 3);
    // Clock enable low freezes the period count
    ce <= 1'b0;
    repeat (200) @(posedge clock);
    ce <= 1'b1;
    rise(n, h);
    chk(n, 980, 1060);
    // Enable cleared: switch stays off
    wr(`QR_CTRL_OFS, 32'h0, r);
    h = 0;
    repeat (1500)
    begin
      @(posedge clock);
      h += gate_on;
    end
    chk(h, 0, 0);
    wr(`QR_CTRL_OFS, 32'h1, r);
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_starter();
    t_qr();
    t_stuck();
    results();
  end
endmodule
